// *** dma_suspend_pkg.sv ***
// Function
// R01: With finish-block policy under halt, all remaining transfers of current block complete.
// R02: With ignore policy, halt is disregarded and transfers proceed normally.
// R03: Each channel selects frame or whole-block triggering; suspend works for both.
// R04: Under finish-block halt, every arriving frame request is honoured until block ends.
// R05: On resume no transfer belonging to earlier requests is lost.
// R06: After block ends during halt, no new block starts until suspend deasserts.
//
// Purpose: Shared constants for the debug suspend aware transfer sequencer.
// Assumes: One clock, asynchronous active high reset.
// Notes:   Policy codes follow the two-bit halt policy field.
package dma_suspend_pkg;
    localparam logic [1:0] POLICY_IGNORE = 2'h0;
    localparam logic [1:0] POLICY_FINISH = 2'h1;
    localparam logic       KIND_FRAME    = 1'h0;
    localparam logic       KIND_BLOCK    = 1'h1;
    localparam int         FRAME_W       = 8;
    localparam int         ELEM_W        = 8;
    localparam int         PEND_W        = 8;
endpackage

// *** dma_debug_suspend_control.sv ***
// Purpose: One channel transfer sequencer with debugger halt handling.
// Assumes: Requests are single-cycle pulses synchronous to mclk.
// Notes:   Pending frame requests are counted in a saturating counter, so none are lost while halted until it fills.
`timescale 1ns/1ps
module dma_debug_suspend_control
    import dma_suspend_pkg::*;
#(
    parameter int FW = FRAME_W,
    parameter int EW = ELEM_W,
    parameter int PW = PEND_W
) (
    input  wire logic          mclk,            // System clock, 20 MHz.
    input  wire logic          reset,           // Async reset, active high.
    input  wire logic [1:0]    halt_policy_field, // Suspend policy code.
    input  wire logic          request_trigger_kind, // 0 frame, 1 block.
    input  wire logic [FW-1:0] frames_per_block, // Frames in a block.
    input  wire logic [EW-1:0] elems_per_frame, // Elements per frame.
    input  wire logic          suspend,         // Debugger halt, level.
    input  wire logic          periph_req,      // Peripheral request pulse.
    input  wire logic          xfer_ready,      // Bus accepts an element.
    output logic               xfer_valid,      // Element transfer request.
    output logic               block_done,      // Block finished pulse.
    output logic               busy,            // Block in progress.
    output logic [PW-1:0]      pending_reqs     // Frame requests waiting.
);

    // Refuse sizes that the counters cannot serve. A single pending slot
    // could not hold a request that lands while another is consumed.
    if (FW < 1 || EW < 1 || PW < 2) begin : g_bad_widths
        $error("dma_debug_suspend_control: bad widths");
    end

    // Every check in this module samples on mclk and stands down while
    // reset is high, so they share one default clock and condition.
    default clocking check_clk @(posedge mclk);
    endclocking

    default disable iff (reset);

    // Idle, waiting for a frame request, or moving elements.
    typedef enum logic [1:0] {S_IDLE, S_WAIT, S_MOVE} st_t;

    // The whole state of the channel; one register holds all of it.
    typedef struct packed {
        st_t           st;
        logic          kind;
        logic [FW-1:0] frame;
        logic [EW-1:0] elem;
        logic [PW-1:0] pend;
        logic          done;
    } state_t;

    state_t s_q, s_d;

    ////////////////////////////////////////////////////////////////////
    // Policy decoding. Both halt tests read the same two-bit code, so
    // the decoding lives in one place.

    // True while a halt is in force under a policy that honours it.
    function automatic logic halt_honoured(input logic       halted,
                                           input logic [1:0] code);
        return halted && (code != POLICY_IGNORE);
    endfunction

    // True while a halt is in force under a code that is neither ignore
    // nor finish. Such codes freeze the block at once, the safe reading.
    function automatic logic halt_freezes(input logic       halted,
                                          input logic [1:0] code);
        return halt_honoured(halted, code) && (code != POLICY_FINISH);
    endfunction

    // Halt blocks a new block when policy honours it; only unknown codes also stop a running block.
    logic hold_new;
    logic stop_now;
    logic last_elem;
    logic last_frame;

    ////////////////////////////////////////////////////////////////////
    // Halt qualification.
    always_comb begin
        hold_new = halt_honoured(suspend, halt_policy_field); // R06
        // Unknown codes stop at once, the safe reading of a halt.
        stop_now = halt_freezes(suspend, halt_policy_field); // R02
        last_elem  = (s_q.elem == elems_per_frame - EW'(1));
        last_frame = (s_q.frame == frames_per_block - FW'(1));
    end

    ////////////////////////////////////////////////////////////////////
    // Next-state logic. Requests are counted rather than latched so
    // that back-to-back frame requests during a halt all survive.
    always_comb begin
        s_d      = s_q;
        s_d.done = 1'b0;
        // Count every request; saturate rather than wrap.
        if (periph_req && !(&s_q.pend))
            s_d.pend = s_q.pend + PW'(1); // R04 R05
        case (s_q.st)
            S_IDLE: begin
                if (s_q.pend != '0 && !hold_new) begin // R06
                    s_d.pend  = s_d.pend - PW'(1);
                    s_d.kind  = request_trigger_kind; // R03
                    s_d.frame = '0;
                    s_d.elem  = '0;
                    s_d.st    = S_MOVE;
                end
            end
            S_WAIT: begin
                // Frame mode takes the next request unless a halt freezes the block.
                if (s_q.pend != '0 && !stop_now) begin // R01 R04
                    s_d.pend = s_d.pend - PW'(1);
                    s_d.st   = S_MOVE;
                end
            end
            S_MOVE: begin
                if (xfer_ready && !stop_now) begin // R01 R02
                    s_d.elem = s_q.elem + EW'(1);
                    if (last_elem) begin
                        s_d.elem = '0;
                        if (last_frame) begin
                            s_d.done = 1'b1;
                            s_d.st   = S_IDLE;
                        end else begin
                            s_d.frame = s_q.frame + FW'(1);
                            s_d.st = (s_q.kind == KIND_FRAME) ? S_WAIT
                                                              : S_MOVE; // R03
                        end
                    end
                end
            end
            default: s_d.st = S_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // State register.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs. Valid is combinational as a handshake output.
    assign xfer_valid   = (s_q.st == S_MOVE) && !stop_now;
    assign block_done   = s_q.done;
    assign busy         = (s_q.st != S_IDLE);
    assign pending_reqs = s_q.pend;

    ////////////////////////////////////////////////////////////////////
    // Checks.

    // Halted under the finish policy with no block running.
    sequence halted_idle;
        suspend && halt_policy_field == POLICY_FINISH && s_q.st == S_IDLE;
    endsequence

    // An element is on offer and the far side takes it this cycle.
    sequence offer_taken;
        s_q.st == S_MOVE && xfer_ready;
    endsequence

    // The position in the block moved on. Element, frame or state always
    // changes on an accept, whatever sizes the inputs give.
    sequence position_moved;
        !$stable({s_q.st, s_q.frame, s_q.elem});
    endsequence

    // Element, frame and state all kept their values.
    sequence position_held;
        $stable({s_q.st, s_q.frame, s_q.elem});
    endsequence

    // Once the block has ended, an honoured halt keeps the channel idle.
    AST_NO_NEW_BLOCK: assert property ( // R06
        halted_idle |=> s_q.st == S_IDLE)
        else $error("block started during halt");

    // Under the finish policy every accepted element advances the block.
    AST_FINISH_MOVES: assert property ( // R01
        (suspend && halt_policy_field == POLICY_FINISH) ##0 offer_taken
        |=> position_moved)
        else $error("finish policy stalled transfer");

    // Under the ignore policy the halt has no effect at all.
    AST_IGNORE_MOVES: assert property ( // R02
        (halt_policy_field == POLICY_IGNORE) ##0 offer_taken
        |=> position_moved)
        else $error("ignore policy stalled transfer");

    // A request that meets a held idle channel is kept for later.
    AST_REQ_COUNTED: assert property ( // R04
        periph_req && s_q.st == S_IDLE && !(&s_q.pend) && hold_new
        |=> s_q.pend == $past(s_q.pend) + PW'(1))
        else $error("request lost during halt");

    // A waiting frame with a request in hand moves on the next cycle.
    AST_FRAME_WAKE: assert property ( // R05
        s_q.st == S_WAIT && s_q.pend != '0 && !stop_now |=> s_q.st == S_MOVE)
        else $error("pending frame request not served");

    // Block trigger never stops to wait for a further request.
    AST_BLOCK_CONT: assert property ( // R03
        s_q.st == S_MOVE && s_q.kind == KIND_BLOCK |=> s_q.st != S_WAIT)
        else $error("block trigger waited for request");

    // A halted frame channel under the finish policy still wakes for
    // each frame request, up to the end of the block.
    AST_HALT_FRAME_WAKE: assert property ( // R04
        suspend && halt_policy_field == POLICY_FINISH && s_q.st == S_WAIT
        && s_q.pend != '0 |=> s_q.st == S_MOVE)
        else $error("halted frame request not served");

    // A frame in motion never consumes a request, so the count must rise;
    // this is what keeps the third and later requests alive.
    AST_REQ_KEPT_MOVE: assert property ( // R05
        periph_req && s_q.st == S_MOVE && !(&s_q.pend)
        |=> s_q.pend == $past(s_q.pend) + PW'(1))
        else $error("request lost while a frame moved");

    // Codes that are neither ignore nor finish freeze the block in place.
    AST_STOP_FREEZES: assert property ( // R02
        stop_now && s_q.st != S_IDLE |=> position_held)
        else $error("block moved under stop policy");

    // The finish pulse lasts one cycle and always leaves the channel idle.
    AST_DONE_PULSE: assert property ( // R01
        block_done |-> s_q.st == S_IDLE ##1 !block_done)
        else $error("block finish pulse malformed");

endmodule // dma_debug_suspend_control

// *** dma_req_model.sv ***
// Purpose: Request source and element sink facing the sequencer.
// Assumes: The bench raises fire for one cycle per request.
// Notes:   Slow mode stalls every other cycle.
`timescale 1ns/1ps
module dma_req_model (
    input  wire logic       mclk,       // System clock.
    input  wire logic       reset,      // Async reset.
    input  wire logic       fire,       // Issue one request.
    input  wire logic       slow,       // Stall alternate cycles.
    input  wire logic       xfer_valid, // Element offered.
    output logic            periph_req, // Request pulse.
    output logic            xfer_ready, // Element accepted.
    output logic [7:0]      taken       // Elements accepted.
);
    // Toggling ready forces the sequencer to hold each offer.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            periph_req <= 1'b0;
            xfer_ready <= 1'b0;
            taken      <= 8'h00;
        end else begin
            periph_req <= fire;
            xfer_ready <= slow ? ~xfer_ready : 1'b1;
            if (xfer_valid && xfer_ready) begin
                taken <= taken + 8'h01;
            end
        end
    end
endmodule // dma_req_model

// *** dma_debug_suspend_control_bench.sv ***
// Purpose: Checks halt handling with three frames of two elements.
// Assumes: Six elements make one block.
// Notes:   Requests sent while halted must all survive.
`timescale 1ns/1ps
module dma_debug_suspend_control_bench;
    import dma_suspend_pkg::*;
    logic       mclk, reset, suspend, fire, slow, kind, busy;
    logic       periph_req, xfer_valid, xfer_ready, block_done;
    logic [1:0] policy;
    logic [7:0] pending_reqs, taken;
    int         miscompares = 0;
    int         comparisons = 0;
    dma_debug_suspend_control i_dma_debug_suspend_control (.mclk(mclk),
        .reset(reset), .halt_policy_field(policy),
        .request_trigger_kind(kind), .frames_per_block(8'h03),
        .elems_per_frame(8'h02), .suspend(suspend),
        .periph_req(periph_req), .xfer_ready(xfer_ready),
        .xfer_valid(xfer_valid), .block_done(block_done), .busy(busy),
        .pending_reqs(pending_reqs));
    dma_req_model i_dma_req_model (.mclk(mclk), .reset(reset), .fire(fire),
        .slow(slow), .xfer_valid(xfer_valid), .periph_req(periph_req),
        .xfer_ready(xfer_ready), .taken(taken));
    // Ends the run with the counts and the verdict.
    task automatic conclude();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge mclk);
            fire <= 1'b1;
            @(posedge mclk);
            fire <= 1'b0;
        end
    endtask
    // Bounded wait; a missing pulse counts as a mismatch.
    task automatic wait_done();
        for (int i = 0; i < 300; i++) begin
            @(posedge mclk);
            #1;
            if (block_done === 1'b1) return;
        end
        miscompares++;
        conclude();
    endtask
    // Finish policy, frame trigger: two frame requests land in the halt,
    // the block completes, and three more wait for the resume.
    task automatic scenario_finish_frame();
        logic [7:0] base;
        @(posedge mclk);
        policy <= POLICY_FINISH;
        kind   <= KIND_FRAME;
        slow   <= 1'b0;
        base = taken;
        pulse(1);
        repeat (3) @(posedge mclk);
        suspend <= 1'b1;
        pulse(2);
        wait_done();
        chk(taken - base, 8'h06);
        pulse(3);
        repeat (6) @(posedge mclk);
        #1;
        chk({7'h00, busy}, 8'h00);
        chk(pending_reqs, 8'h03);
        @(posedge mclk);
        suspend <= 1'b0;
        wait_done();
        chk(taken - base, 8'h0C);
    endtask
    // Finish policy, block trigger, with a stalling sink.
    task automatic scenario_finish_block();
        logic [7:0] base;
        @(posedge mclk);
        policy <= POLICY_FINISH;
        kind   <= KIND_BLOCK;
        slow   <= 1'b1;
        base = taken;
        pulse(1);
        repeat (3) @(posedge mclk);
        suspend <= 1'b1;
        wait_done();
        chk(taken - base, 8'h06);
        pulse(1);
        repeat (6) @(posedge mclk);
        #1;
        chk({7'h00, busy}, 8'h00);
        chk(pending_reqs, 8'h01);
        @(posedge mclk);
        suspend <= 1'b0;
        wait_done();
        chk(taken - base, 8'h0C);
    endtask
    // Ignore policy: a new block starts even though the halt stands.
    task automatic scenario_ignore_frame();
        logic [7:0] base;
        @(posedge mclk);
        policy <= POLICY_IGNORE;
        kind   <= KIND_FRAME;
        slow   <= 1'b0;
        base = taken;
        pulse(1);
        repeat (3) @(posedge mclk);
        suspend <= 1'b1;
        pulse(2);
        wait_done();
        chk(taken - base, 8'h06);
        pulse(1);
        repeat (2) @(posedge mclk);
        #1;
        chk({7'h00, busy}, 8'h01);
        pulse(2);
        wait_done();
        chk(taken - base, 8'h0C);
        @(posedge mclk);
        suspend <= 1'b0;
    endtask
    // A code that is neither ignore nor finish freezes the block after
    // its first element; the rest follows once the halt is released.
    task automatic scenario_stop_code();
        logic [7:0] base;
        @(posedge mclk);
        policy <= 2'h2;
        kind   <= KIND_BLOCK;
        slow   <= 1'b0;
        base = taken;
        pulse(1);
        repeat (3) @(posedge mclk);
        suspend <= 1'b1;
        repeat (12) @(posedge mclk);
        #1;
        chk(taken - base, 8'h01);
        chk({7'h00, xfer_valid}, 8'h00);
        chk({7'h00, busy}, 8'h01);
        @(posedge mclk);
        suspend <= 1'b0;
        wait_done();
        chk(taken - base, 8'h06);
    endtask
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    initial begin
        reset = 1'b1;
        suspend = 1'b0;
        fire = 1'b0;
        slow = 1'b0;
        kind = KIND_FRAME;
        policy = POLICY_FINISH;
        repeat (8) @(posedge mclk);
        reset <= 1'b0;
        scenario_finish_frame();
        scenario_finish_block();
        scenario_ignore_frame();
        scenario_stop_code();
        conclude();
    end
endmodule // dma_debug_suspend_control_bench
